// ===== hdl/pbyc_regs.svh
// Purpose: timing and reset constants for the primary bus yield control block
// Assumes: clock of 200 MHz, one clock_phase_one cycle per core clock
// Notes:   definitions only
`ifndef PBYC_REGS_SVH
`define PBYC_REGS_SVH
`define PBYC_CLK_PERIOD_NS      5
`define PBYC_GRANT_TAIL_NS      5
`define PBYC_GRANT_TAIL_CYC     ((`PBYC_GRANT_TAIL_NS + `PBYC_CLK_PERIOD_NS - 1) / `PBYC_CLK_PERIOD_NS)
`define PBYC_GRANT_RST          1'b1
`define PBYC_ADDR_W             24
`define PBYC_DATA_W             32
`endif

// ===== hdl/pbyc_pkg.sv
// Purpose: types for the primary bus yield control block
// Assumes: regs header included for widths
// Notes:   states are one-hot
`include "pbyc_regs.svh"
package pbyc_pkg;
    typedef enum logic [3:0] {
        PBYC_OWN   = 4'h1,   // core owns the bus
        PBYC_QUIET = 4'h2,   // strobes driven inactive
        PBYC_YIELD = 4'h4,   // bus released
        PBYC_TAIL  = 4'h8    // grant held one extra phase
    } pbyc_state_e;
endpackage

// ===== hdl/pbyc_sync_if.sv
// Purpose: carries the synchronised request between modules
// Assumes: one clock
// Notes:   single level signal
interface pbyc_sync_if;
    logic req_low;
    modport src (output req_low);
    modport dst (input  req_low);
endinterface

// ===== hdl/pbyc_sync.sv
// Purpose: two flip-flop synchroniser for the asynchronous yield request
// Assumes: bus_yield_req_n may change anywhere in the cycle
// Notes:   output is active high request
module pbyc_sync (
    input  wire logic  clock,
    input  wire logic  rst_n,
    input  wire logic  bus_yield_req_n,
    pbyc_sync_if.src   sync
);
    typedef struct packed {
        logic meta;
        logic stable;
    } pbyc_sync_s;
    pbyc_sync_s s_q;
    pbyc_sync_s s_d;

    // first stage read only by second
    always_comb begin
        s_d        = s_q;
        s_d.meta   = ~bus_yield_req_n;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync.req_low = s_q.stable;
endmodule // pbyc_sync

// ===== hdl/pbyc_top.sv
// Purpose: lets an external master take the primary bus from the core
// Assumes: core presents one access at a time with acc_req held until acc_done
// Notes:   one pending write absorbed during a yield
//
// Behaviour
// - request is asynchronous, synchronised before use
// - late request lags at most one cycle
// - inhibit bit overrides the yield request
// - inhibit during yield reclaims bus, refuses more
// - no core bus access while yield honoured
// - core runs on, stalls only on bus
// - one write may pend; second write stalls
// - grant low until one phase after release
`include "pbyc_regs.svh"
module pbyc_top #(
    parameter int ADDR_W = `PBYC_ADDR_W,
    parameter int DATA_W = `PBYC_DATA_W
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              bus_yield_req_n,
    input  wire logic              yield_inhibit,
    input  wire logic              acc_req,
    input  wire logic              acc_write,
    input  wire logic [ADDR_W-1:0] acc_addr,
    input  wire logic [DATA_W-1:0] acc_wdata,
    output logic                   acc_stall,
    output logic                   acc_done,
    output logic [DATA_W-1:0]      acc_rdata,
    output logic                   bus_yield_grant_n,
    output logic                   strobe_n_o,
    output logic                   strobe_oe,
    output logic                   rw_o,
    output logic                   rw_oe,
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   addr_oe,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              bus_ready
);
    typedef struct packed {
        pbyc_pkg::pbyc_state_e st;
        logic                  grant_n;
        logic                  busy;
        logic                  pend;
        logic                  pend_taken;
        logic [ADDR_W-1:0]     pend_addr;
        logic [DATA_W-1:0]     pend_data;
        logic                  strobe_n;
        logic                  rw;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
        logic                  drive;
        logic                  stall;
        logic                  done;
        logic [DATA_W-1:0]     rdata;
    } pbyc_s;

    pbyc_s       r_q;
    pbyc_s       r_d;
    pbyc_sync_if sync_if ();
    logic        want;
    logic        can_take;

    // both flops of the request synchroniser live in the leaf
    pbyc_sync u_sync (
        .clock           (clock),
        .rst_n           (rst_n),
        .bus_yield_req_n (bus_yield_req_n),
        .sync            (sync_if.src)
    );

    // inhibit masks the request outright
    assign want     = sync_if.req_low && !yield_inhibit;
    assign can_take = !r_q.busy && r_q.st == pbyc_pkg::PBYC_OWN;

    always_comb begin
        r_d      = r_q;
        r_d.done = 1'b0;
        case (r_q.st)
            pbyc_pkg::PBYC_OWN: begin
                // finish a running cycle before yielding
                if (want && !r_q.busy) begin
                    r_d.st       = pbyc_pkg::PBYC_QUIET;
                    r_d.strobe_n = 1'b1;
                end
            end
            pbyc_pkg::PBYC_QUIET: begin
                // inhibit arriving here must not let the grant go out
                if (yield_inhibit) begin
                    r_d.st = pbyc_pkg::PBYC_OWN;
                end else begin
                    r_d.st      = pbyc_pkg::PBYC_YIELD;
                    r_d.drive   = 1'b0;
                    r_d.grant_n = 1'b0;
                end
            end
            pbyc_pkg::PBYC_YIELD: begin
                if (yield_inhibit) begin
                    r_d.st      = pbyc_pkg::PBYC_OWN;
                    r_d.drive   = 1'b1;
                    r_d.grant_n = 1'b1;
                end else if (!sync_if.req_low) begin
                    r_d.st = pbyc_pkg::PBYC_TAIL;
                end
            end
            pbyc_pkg::PBYC_TAIL: begin
                // one more phase of grant, then take bus back
                r_d.st      = pbyc_pkg::PBYC_OWN;
                r_d.drive   = 1'b1;
                r_d.grant_n = 1'b1;
            end
            default: begin
                r_d.st = pbyc_pkg::PBYC_OWN;
            end
        endcase

        // bus cycle completion
        if (r_q.busy && bus_ready) begin
            r_d.busy     = 1'b0;
            r_d.strobe_n = 1'b1;
            if (!r_q.pend_taken) begin
                r_d.done  = 1'b1;
                r_d.rdata = data_i;
            end
            r_d.pend_taken = 1'b0;
        end

        r_d.stall = 1'b0;
        if (acc_req && !r_q.done) begin
            if (r_q.st != pbyc_pkg::PBYC_OWN || r_q.busy) begin
                // write buffered so the core keeps running
                if (acc_write && !r_q.pend && !r_q.stall) begin
                    r_d.pend      = 1'b1;
                    r_d.pend_addr = acc_addr;
                    r_d.pend_data = acc_wdata;
                    r_d.done      = 1'b1;
                end else begin
                    r_d.stall = 1'b1;
                end
            end else if (r_q.pend) begin
                r_d.stall = 1'b1; // pending write drains first
            end else if (!want) begin
                r_d.busy     = 1'b1;
                r_d.strobe_n = 1'b0;
                r_d.rw       = !acc_write;
                r_d.addr     = acc_addr;
                r_d.wdata    = acc_wdata;
            end else begin
                r_d.stall = 1'b1;
            end
        end

        // flush the pending write once the bus is ours again
        if (r_q.pend && can_take && !want && !r_d.busy) begin
            r_d.pend       = 1'b0;
            r_d.busy       = 1'b1;
            r_d.pend_taken = 1'b1;
            r_d.strobe_n   = 1'b0;
            r_d.rw         = 1'b0;
            r_d.addr       = r_q.pend_addr;
            r_d.wdata      = r_q.pend_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r_q          <= '0;
            r_q.st       <= pbyc_pkg::PBYC_OWN;
            r_q.grant_n  <= `PBYC_GRANT_RST;
            r_q.strobe_n <= 1'b1;
            r_q.rw       <= 1'b1;
            r_q.drive    <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign acc_stall         = r_q.stall;
    assign acc_done          = r_q.done;
    assign acc_rdata         = r_q.rdata;
    assign bus_yield_grant_n = r_q.grant_n;
    assign strobe_n_o        = r_q.strobe_n;
    assign strobe_oe         = r_q.drive;
    assign rw_o              = r_q.rw;
    assign rw_oe             = r_q.drive;
    assign addr_o            = r_q.addr;
    assign addr_oe           = r_q.drive;
    assign data_o            = r_q.wdata;
    assign data_oe           = r_q.drive && !r_q.rw && r_q.busy;
endmodule // pbyc_top

// ===== verification/pbyc_chk.sv
// Purpose: port assertions for the yield controller
// Assumes: one clock, sync active-low reset
// Notes:   bound to pbyc_top
module pbyc_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic bus_yield_req_n,
    input wire logic yield_inhibit,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_stall,
    input wire logic acc_done,
    input wire logic bus_yield_grant_n,
    input wire logic strobe_n_o,
    input wire logic strobe_oe,
    input wire logic rw_oe,
    input wire logic addr_oe,
    input wire logic data_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic g = bus_yield_grant_n;
    logic      wr_yield_q;
    // remembers that this yield already absorbed its one write
    always @(posedge clock) begin
        if (!rst_n || g) wr_yield_q <= 1'b0;
        else if (acc_done) wr_yield_q <= 1'b1;
    end
    // grant stays low three edges after release, then returns
    sequence s_held; !g[*3]; endsequence
    sequence s_back; ##[1:3] g; endsequence
    property p_inh; yield_inhibit |=> g; endproperty
    property p_rec; yield_inhibit && !g |=> strobe_oe && addr_oe && rw_oe; endproperty
    property p_quiet; $fell(g) |-> $past(strobe_n_o); endproperty
    property p_off; !g |-> !strobe_oe && !addr_oe && !rw_oe && !data_oe; endproperty
    // idle bus assumed so no cycle delays the yield
    property p_lat; (!bus_yield_req_n && !yield_inhibit && !acc_req)[*6] |-> !g; endproperty
    property p_tail; $rose(bus_yield_req_n) && !g && !yield_inhibit |-> s_held ##0 s_back; endproperty
    property p_rd; !g && $past(!g) && acc_req && $past(acc_req) && !acc_write |-> acc_stall && !acc_done;
    endproperty
    property p_wr; $rose(acc_req) && acc_write && !g && !wr_yield_q |-> ##[0:2] acc_done; endproperty
    property p_wr2; $rose(acc_req) && acc_write && !g && wr_yield_q |=> acc_stall && !acc_done; endproperty
    a_inh: assert property (p_inh) else $error("grant while inhibited");
    a_rec: assert property (p_rec) else $error("bus not reclaimed");
    a_quiet: assert property (p_quiet) else $error("strobe active at yield");
    a_off: assert property (p_off) else $error("pins driven in yield");
    a_lat: assert property (p_lat) else $error("yield too late");
    a_tail: assert property (p_tail) else $error("grant tail wrong");
    a_rd: assert property (p_rd) else $error("read not stalled");
    a_wr: assert property (p_wr) else $error("write not absorbed");
    a_wr2: assert property (p_wr2) else $error("second write not stalled");
endmodule // pbyc_chk
bind pbyc_top pbyc_chk pbyc_chk_inst (.clock, .rst_n, .bus_yield_req_n, .yield_inhibit, .acc_req, .acc_write,
    .acc_stall, .acc_done, .bus_yield_grant_n, .strobe_n_o, .strobe_oe, .rw_oe, .addr_oe, .data_oe);

// ===== verification/pbyc_master.sv
// Purpose: far side: requesting master and primary memory
// Assumes: bench holds yield_want for at least two cycles
// Notes:   data_i toggles whenever it is not valid
module pbyc_master (
    input  wire logic        clock,
    input  wire logic        yield_want,
    input  wire logic        slow,
    input  wire logic        strobe_n_o,
    input  wire logic        strobe_oe,
    input  wire logic [23:0] addr_o,
    output logic             bus_yield_req_n,
    output logic [31:0]      data_i,
    output logic             bus_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_q = 0;
    initial bus_yield_req_n = 1'b1;
    initial bus_ready = 1'b0;
    initial data_i = 32'h0;
    // request moves just after the edge, held as long as wanted
    always @(posedge clock) bus_yield_req_n <= !yield_want;
    // memory answers after 0 or 3 waits; gap after each ready
    always @(negedge clock) begin
        bus_ready <= 1'b0;
        data_i <= ~data_i;
        if (strobe_oe && !strobe_n_o && !bus_ready) begin
            if (wait_q >= (slow ? 3 : 0)) begin
                bus_ready <= 1'b1;
                data_i <= {8'h00, addr_o} ^ 32'h5a5a5a5a;
                wait_q <= 0;
            end else wait_q <= wait_q + 1;
        end
    end
endmodule // pbyc_master

// ===== verification/tb.sv
// Purpose: self-checking bench for the yield controller
// Assumes: pbyc_master plays memory and requester
// Notes:   seed fixed at 95
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst_n = 1'b0, yield_want = 1'b0, slow = 1'b0, yield_inhibit = 1'b0;
    logic acc_req = 1'b0, acc_write = 1'b0, acc_stall, acc_done, bus_yield_grant_n, bus_yield_req_n;
    logic strobe_n_o, strobe_oe, rw_o, rw_oe, addr_oe, data_oe, bus_ready, ok;
    logic [23:0] acc_addr = 24'h0, addr_o, a;
    logic [31:0] acc_wdata = 32'h0, acc_rdata, data_o, data_i, rd, wr_seen;
    int err_total = 0, comparisons = 0;
    pbyc_top pbyc_top_inst (.*);
    pbyc_master pbyc_master_inst (.*);
    initial forever #2.5 clock = ~clock;
    // last write that reached the pins
    always @(posedge clock) if (strobe_oe && !strobe_n_o && !rw_o && bus_ready) wr_seen <= data_o;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    function logic [31:0] mem(input logic [23:0] ad);
        return {8'h00, ad} ^ 32'h5a5a5a5a;
    endfunction
    task cyc(input int n); repeat (n) @(negedge clock); endtask
    // one core access, held until done or n edges
    task acc(input logic w, input logic [23:0] ad, input int n);
        acc_req = 1'b1; acc_write = w; acc_addr = ad; acc_wdata = ~mem(ad); ok = 1'b0;
        repeat (n) begin
            @(posedge clock); #1;
            if (acc_done === 1'b1) begin ok = 1'b1; rd = acc_rdata; break; end
        end
        @(negedge clock); acc_req = 1'b0;
        // one idle cycle so a following call never re-raises at once
        @(negedge clock);
    endtask
    task conclude;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles needed
    initial begin #20000; err_total++; conclude; end
    initial begin
        a = 24'($urandom(95));
        cyc(8); rst_n = 1'b1; cyc(1);
        chk({bus_yield_grant_n, strobe_oe, data_oe}, 3'b110);
        repeat (16) begin
            a = 24'($urandom); slow = 1'($urandom);
            acc(1'b0, a, 20); chk(rd, mem(a));
            acc(1'b1, a, 20); cyc(2); chk(wr_seen, ~mem(a));
        end
        yield_want = 1'b1; cyc(7);
        chk({bus_yield_grant_n, strobe_oe, addr_oe, data_oe}, 4'h0);
        acc(1'b1, a, 3); chk(ok, 1'b1);
        acc(1'b1, a + 24'h2, 3); chk(ok, 1'b0);
        fork
            acc(1'b0, a + 24'h1, 40);
            begin cyc(8); chk({acc_stall, strobe_oe}, 2'b10); yield_want = 1'b0; end
        join
        chk(ok, 1'b1);
        chk(rd, mem(a + 24'h1));
        chk(wr_seen, ~mem(a));
        yield_inhibit = 1'b1; yield_want = 1'b1; cyc(8);
        chk(bus_yield_grant_n, 1'b1);
        yield_inhibit = 1'b0; cyc(7);
        chk(bus_yield_grant_n, 1'b0);
        yield_inhibit = 1'b1; cyc(2);
        chk({bus_yield_grant_n, strobe_oe}, 2'h3);
        acc(1'b0, a, 20); chk(rd, mem(a));
        yield_want = 1'b0; yield_inhibit = 1'b0; cyc(4);
        conclude;
    end
endmodule // tb
